// file: cdi_assertions.sv
module cdi_assertions (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_tick_in,
  input wire logic sleep_instr_in,
  input wire logic irq_pending_in,
  input wire logic watchdog_timeout_in,
  input wire logic clock_output_cfg_in,
  input wire logic cpu_exec_out,
  input wire logic prog_fetch_out,
  input wire logic cpu_clk_en_out,
  input wire logic sys_clk_en_out,
  input wire logic periph_main_clk_en_out,
  input wire logic periph_instr_tick_out,
  input wire logic internal_osc_clk_en_out,
  input wire logic clock_output_pin_en_out,
  input wire logic watchdog_reset_out,
  input wire logic idle_out,
  input wire logic sleep_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  // First idle cycle skipped: an execute pulse may still trail the sleep tick
  a_idle_no_cpu: assert property (
    idle_out && $past(idle_out) |-> !cpu_clk_en_out && !cpu_exec_out && !prog_fetch_out)
    else $error("cpu active in idle");
  a_sleep_clk_off: assert property (
    sleep_out |-> !sys_clk_en_out && !cpu_clk_en_out && !periph_main_clk_en_out)
    else $error("clocks running in sleep");
  a_main_clk_on: assert property (
    !sleep_out |-> periph_main_clk_en_out && internal_osc_clk_en_out)
    else $error("peripheral clock lost outside sleep");
  a_clock_output_pin_idle: assert property (
    idle_out && $past(clock_output_cfg_in) |-> clock_output_pin_en_out)
    else $error("clock output stopped in idle");
  a_wdt_blocked: assert property (
    idle_out && watchdog_timeout_in |=> !watchdog_reset_out && !idle_out)
    else $error("watchdog did not wake idle");
  a_tick_passes: assert property (
    !sleep_out && !sleep_instr_in |=> periph_instr_tick_out == $past(instr_tick_in))
    else $error("peripheral tick not forwarded");
  a_sleep_entry: assert property (
    sleep_instr_in && !irq_pending_in && !idle_out && !sleep_out |=> idle_out ^ sleep_out)
    else $error("sleep instruction ignored");
  a_irq_wakes: assert property (
    (idle_out || sleep_out) && $rose(irq_pending_in) |=> !idle_out && !sleep_out)
    else $error("interrupt did not end low power");
  a_exec_on_tick: assert property (
    cpu_exec_out |-> $past(instr_tick_in))
    else $error("execute without tick");
  c_idle_wdt: cover property (idle_out && watchdog_timeout_in);
  c_sleep: cover property ($rose(sleep_out));
  c_idle_irq: cover property (idle_out && $rose(irq_pending_in));
endmodule

bind cdi_power_ctrl cdi_assertions u_chk (
  .sys_clk_in, .rst_n_in, .instr_tick_in, .sleep_instr_in, .irq_pending_in,
  .watchdog_timeout_in, .clock_output_cfg_in, .cpu_exec_out, .prog_fetch_out,
  .cpu_clk_en_out, .sys_clk_en_out, .periph_main_clk_en_out, .periph_instr_tick_out,
  .internal_osc_clk_en_out, .clock_output_pin_en_out, .watchdog_reset_out,
  .idle_out, .sleep_out
);

// file: cdi_core_model.sv
module cdi_core_model (
  input  wire logic clk_in,
  input  wire logic tick_en_in,
  output logic      tick_out,
  output logic      sleep_ev_out,
  output logic      rfi_ev_out,
  output logic      wdt_ev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ev = 3'h0;
  assign sleep_ev_out = ev[0];
  assign rfi_ev_out   = ev[1];
  assign wdt_ev_out   = ev[2];
  // Tick every other clock so counts over a window are exact
  always @(posedge clk_in) begin
    tick_out <= tick_en_in && !tick_out;
  end
  // One-cycle event: 0 sleep, 1 return from interrupt, 2 watchdog
  task automatic pulse(input int k);
    @(posedge clk_in);
    ev[k] <= 1'b1;
    @(posedge clk_in);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
endmodule

// file: cdi_pkg.sv
package cdi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port and throttle counter geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields (cpu_power_control_reg)
  localparam int unsigned RATIO_LSB  = 0;
  localparam int unsigned RATIO_W    = 3;
  localparam int unsigned RETHR_BIT  = 4;
  localparam int unsigned WFS_BIT    = 5;
  localparam int unsigned THR_EN_BIT = 6;
  localparam int unsigned LHS_BIT    = 7;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  CTRL_MASK  = 8'hf7;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int unsigned STAT_IDLE_BIT  = 0;
  localparam int unsigned STAT_SLEEP_BIT = 1;
  localparam int unsigned STAT_THR_BIT   = 2;
  localparam int unsigned STAT_WDW_BIT   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Power modes
  typedef enum logic [1:0] {
    CDI_RUN,
    CDI_IDLE,
    CDI_SLEEP
  } cdi_mode_type;

  ////////////////////////////////////////////////////////////////////////////
  // Last count of a throttle period: ratio code c gives 1 in 2^(c+1)
  function automatic logic [7:0] cdi_ratio_last(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h002 << code;
    return n[7:0] - 8'h01;
  endfunction

endpackage

// file: cdi_power_ctrl.sv
// Local design decisions: the register addresses and the address-and-strobe port.
module cdi_power_ctrl
  import cdi_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  input  wire logic              instr_tick_in,
  input  wire logic              sleep_instr_in,
  input  wire logic              return_from_interrupt_in,
  input  wire logic              irq_pending_in,
  input  wire logic              watchdog_timeout_in,
  input  wire logic              clock_output_cfg_in,
  output logic [DATA_W-1:0]      reg_rdata_out,
  output logic                   cpu_exec_out,
  output logic                   prog_fetch_out,
  output logic                   cpu_clk_en_out,
  output logic                   sys_clk_en_out,
  output logic                   periph_main_clk_en_out,
  output logic                   periph_instr_tick_out,
  output logic                   internal_osc_clk_en_out,
  output logic                   clock_output_pin_en_out,
  output logic                   watchdog_reset_out,
  output logic                   idle_out,
  output logic                   sleep_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]   cpu_power_control_reg;
  logic [7:0]   next_ctrl;
  cdi_mode_type mode;
  cdi_mode_type next_mode;
  logic         irq_prev;
  logic         irq_rise;
  logic         wdt_woke;
  logic         restart;
  logic         exec_slot;
  logic         fetch_slot;
  logic         running;
  logic         sleeping;
  logic         cpu_throttle_enable;
  logic         wake_full_speed;
  logic         rethrottle_on_return;
  logic         light_halt_select;
  logic         ctrl_write;

  assign cpu_throttle_enable  = cpu_power_control_reg[THR_EN_BIT];
  assign wake_full_speed      = cpu_power_control_reg[WFS_BIT];
  assign rethrottle_on_return = cpu_power_control_reg[RETHR_BIT];
  assign light_halt_select    = cpu_power_control_reg[LHS_BIT];
  assign ctrl_write           = reg_write_in && (reg_addr_in == CTRL_ADDR);
  assign running              = (mode == CDI_RUN);
  assign sleeping             = (mode == CDI_SLEEP);

  // Main oscillator domain stays up in every mode but Sleep
  function automatic logic main_clk_kept(input cdi_mode_type m);
    return (m != CDI_SLEEP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt arrival: a request that was already pending does not count twice
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= irq_pending_in;
    end
  end

  assign irq_rise = irq_pending_in && !irq_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Control register next value; hardware events override a same-cycle write
  always_comb begin
    next_ctrl = cpu_power_control_reg;
    if (ctrl_write) begin
      next_ctrl = reg_wdata_in & CTRL_MASK;
    end
    // Throttle stays set when wake_full_speed is clear: handler runs slow
    if (irq_rise && wake_full_speed && cpu_throttle_enable) begin
      next_ctrl[THR_EN_BIT] = 1'b0;
    end
    if (return_from_interrupt_in && running && rethrottle_on_return) begin
      next_ctrl[THR_EN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_power_control_reg <= CTRL_RESET;
    end else begin
      // light_halt_select is never touched by a wake
      cpu_power_control_reg <= next_ctrl;
    end
  end

  assign restart = next_ctrl[THR_EN_BIT] && !cpu_throttle_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Power mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      CDI_RUN: begin
        // A sleep issued with an interrupt already pending completes as a no-op
        if (sleep_instr_in && !irq_pending_in) begin
          next_mode = light_halt_select ? CDI_IDLE : CDI_SLEEP;
        end
      end
      CDI_IDLE: begin
        if (irq_rise || watchdog_timeout_in) begin
          next_mode = CDI_RUN;
        end
      end
      CDI_SLEEP: begin
        if (irq_rise || watchdog_timeout_in) begin
          next_mode = CDI_RUN;
        end
      end
      default: begin
        next_mode = CDI_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= CDI_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog wake record; throttle enable is left alone on this path
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdt_woke <= 1'b0;
    end else if (!running && watchdog_timeout_in && !irq_rise) begin
      wdt_woke <= 1'b1;
    end else if (running && next_mode != CDI_RUN) begin
      wdt_woke <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Throttle period counter
  cdi_throttle_counter u_counter (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .tick_in        (instr_tick_in),
    .restart_in     (restart),
    .ratio_in       (cpu_power_control_reg[RATIO_LSB +: RATIO_W]),
    .exec_slot_out  (exec_slot),
    .fetch_slot_out (fetch_slot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // CPU and memory gating; one cycle behind the tick so outputs are flopped
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_exec_out <= 1'b0;
    end else begin
      cpu_exec_out <= instr_tick_in && running
                      && (!cpu_throttle_enable || exec_slot);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prog_fetch_out <= 1'b0;
    end else begin
      prog_fetch_out <= instr_tick_in && running
                        && (!cpu_throttle_enable || fetch_slot);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_clk_en_out <= 1'b1;
    end else begin
      cpu_clk_en_out <= (next_mode == CDI_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral and system clock gating
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_clk_en_out <= 1'b1;
    end else begin
      sys_clk_en_out <= main_clk_kept(next_mode);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_main_clk_en_out <= 1'b1;
    end else begin
      periph_main_clk_en_out <= main_clk_kept(next_mode);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_instr_tick_out <= 1'b0;
    end else begin
      periph_instr_tick_out <= instr_tick_in && !sleeping;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      internal_osc_clk_en_out <= 1'b1;
    end else begin
      internal_osc_clk_en_out <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clock_output_pin_en_out <= 1'b0;
    end else begin
      clock_output_pin_en_out <= clock_output_cfg_in
                                 && main_clk_kept(next_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog reset passes only while running; otherwise it is a wake
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watchdog_reset_out <= 1'b0;
    end else begin
      watchdog_reset_out <= watchdog_timeout_in && running;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode flags follow the next mode so they line up with the clock enables
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_out <= 1'b0;
    end else begin
      idle_out <= (next_mode == CDI_IDLE);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_out <= 1'b0;
    end else begin
      sleep_out <= (next_mode == CDI_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped addresses read zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        CTRL_ADDR: begin
          reg_rdata_out <= cpu_power_control_reg;
        end
        STAT_ADDR: begin
          reg_rdata_out                 <= 8'h00;
          reg_rdata_out[STAT_IDLE_BIT]  <= (mode == CDI_IDLE);
          reg_rdata_out[STAT_SLEEP_BIT] <= sleeping;
          reg_rdata_out[STAT_THR_BIT]   <= cpu_throttle_enable;
          reg_rdata_out[STAT_WDW_BIT]   <= wdt_woke;
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

// file: cdi_throttle_counter.sv
module cdi_throttle_counter
  import cdi_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tick_in,
  input  wire logic       restart_in,
  input  wire logic [2:0] ratio_in,
  output logic            exec_slot_out,
  output logic            fetch_slot_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;

  assign last = cdi_ratio_last(ratio_in);

  ////////////////////////////////////////////////////////////////////////////
  // Count instruction cycles modulo the selected ratio
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 8'h00;
    end else if (restart_in) begin
      count <= 8'h00;
    end else if (tick_in) begin
      // A ratio lowered mid-period wraps at once instead of running to 255
      count <= (count >= last) ? 8'h00 : count + 8'h01;
    end
  end

  // Slot zero executes; the slot before it fetches the coming instruction
  assign exec_slot_out  = (count == 8'h00);
  assign fetch_slot_out = (count == last);

endmodule

// file: tb_top.sv
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR at %0t: got %0h, expected %0h", $time, got, exp); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cdi_pkg::*;
  logic sys_clk_in, rst_n_in, tick_en;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic reg_write_in, reg_read_in, irq_pending_in;
  logic clock_output_cfg_in, instr_tick_in, sleep_instr_in, return_from_interrupt_in;
  logic watchdog_timeout_in, cpu_exec_out, prog_fetch_out, cpu_clk_en_out, sys_clk_en_out;
  logic periph_main_clk_en_out, periph_instr_tick_out, internal_osc_clk_en_out;
  logic clock_output_pin_en_out, watchdog_reset_out, idle_out, sleep_out;
  int n_errors = 0, cmp_count = 0, n_exec = 0, n_fetch = 0, n_ptick = 0, n_wrst = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  cdi_power_ctrl dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .instr_tick_in(instr_tick_in), .sleep_instr_in(sleep_instr_in),
    .return_from_interrupt_in(return_from_interrupt_in), .irq_pending_in(irq_pending_in),
    .watchdog_timeout_in(watchdog_timeout_in), .clock_output_cfg_in(clock_output_cfg_in),
    .reg_rdata_out(reg_rdata_out), .cpu_exec_out(cpu_exec_out),
    .prog_fetch_out(prog_fetch_out), .cpu_clk_en_out(cpu_clk_en_out),
    .sys_clk_en_out(sys_clk_en_out), .periph_main_clk_en_out(periph_main_clk_en_out),
    .periph_instr_tick_out(periph_instr_tick_out),
    .internal_osc_clk_en_out(internal_osc_clk_en_out),
    .clock_output_pin_en_out(clock_output_pin_en_out),
    .watchdog_reset_out(watchdog_reset_out), .idle_out(idle_out), .sleep_out(sleep_out));
  cdi_core_model core (.clk_in(sys_clk_in), .tick_en_in(tick_en), .tick_out(instr_tick_in),
    .sleep_ev_out(sleep_instr_in), .rfi_ev_out(return_from_interrupt_in),
    .wdt_ev_out(watchdog_timeout_in));
  always @(posedge sys_clk_in) begin
    n_exec  <= n_exec + int'(cpu_exec_out);
    n_fetch <= n_fetch + int'(prog_fetch_out);
    n_ptick <= n_ptick + int'(periph_instr_tick_out);
    n_wrst  <= n_wrst + int'(watchdog_reset_out);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic ticks(input int n);
    @(posedge sys_clk_in);
    tick_en <= 1'b1;
    repeat (2 * n) @(posedge sys_clk_in);
    tick_en <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  // Level held a few cycles: wake and throttle clear act on its rising edge only
  task automatic irq_rise;
    @(posedge sys_clk_in);
    irq_pending_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    irq_pending_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] d;
    rd(CTRL_ADDR, d);
    `CHK(d, CTRL_RESET)
    wr(4'h2, 8'hff);
    rd(4'h2, d);
    `CHK(d, 8'h00)
    wr(CTRL_ADDR, 8'hff);
    rd(CTRL_ADDR, d);
    `CHK(d, CTRL_MASK)
    wr(CTRL_ADDR, 8'h00);
  endtask
  // Every ratio code over two full periods; the counter must restart on enable
  task automatic t_ratio;
    int e, f, p;
    for (int c = 0; c < 8; c++) begin
      wr(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h40 | 8'(c));
      e = n_exec;
      f = n_fetch;
      p = n_ptick;
      ticks(4 << c);
      `CHK(n_exec - e, 2)
      `CHK(n_fetch - f, 2)
      `CHK(n_ptick - p, 4 << c)
    end
  endtask
  task automatic t_irq;
    logic [7:0] d;
    int e;
    wr(CTRL_ADDR, 8'h71);
    irq_rise();
    rd(STAT_ADDR, d);
    `CHK(d[2], 1'b0)
    e = n_exec;
    ticks(8);
    `CHK(n_exec - e, 8)
    core.pulse(1);
    rd(STAT_ADDR, d);
    `CHK(d[2], 1'b1)
    wr(CTRL_ADDR, 8'h41);
    irq_rise();
    e = n_exec;
    ticks(8);
    rd(STAT_ADDR, d);
    `CHK({d[2], 6'(n_exec - e)}, 7'h42)
  endtask
  task automatic t_idle;
    logic [7:0] d;
    int e, w;
    clock_output_cfg_in <= 1'b1;
    wr(CTRL_ADDR, 8'h80);
    core.pulse(0);
    `CHK({idle_out, sleep_out, cpu_clk_en_out, sys_clk_en_out}, 4'b1001)
    `CHK({periph_main_clk_en_out, clock_output_pin_en_out}, 2'b11)
    e = n_exec;
    w = n_ptick;
    ticks(4);
    `CHK({n_exec - e, n_ptick - w}, {32'd0, 32'd4})
    irq_rise();
    rd(CTRL_ADDR, d);
    `CHK({idle_out, d[7]}, 2'b01)
    wr(CTRL_ADDR, 8'he1);
    core.pulse(0);
    w = n_wrst;
    core.pulse(2);
    rd(STAT_ADDR, d);
    `CHK({idle_out, n_wrst - w, d[3:2]}, {1'b0, 32'd0, 2'b11})
    core.pulse(0);
    irq_rise();
    rd(STAT_ADDR, d);
    `CHK(d[2:0], 3'b000)
    wr(CTRL_ADDR, 8'h00);
    core.pulse(0);
    `CHK({sleep_out, sys_clk_en_out, clock_output_pin_en_out, internal_osc_clk_en_out},
      4'b1001)
    irq_rise();
    w = n_wrst;
    core.pulse(2);
    `CHK({sleep_out, n_wrst - w}, {1'b0, 32'd1})
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    rst_n_in = 1'b0;
    tick_en = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    irq_pending_in = 1'b0;
    clock_output_cfg_in = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_ratio();
    t_irq();
    t_idle();
    print_verdict();
  end
  // Whole run is near 2300 cycles; stop well past that
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
